// File: hdl/sosc_top.sv
// Purpose: Output stage routing, PWM, alarms, start window, diagnostics
// Assumes: Control bits are static configuration ports
// Notes:   Analog DAC and amplifier are outside this block
`timescale 1ns/10ps
module sosc_top
    import sosc_pkg::*;
#(
    parameter int START_CYC = START_WIN_CYC,
    parameter int WDG_LIM   = WDG_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    // Results from the measurement loop
    input  wire logic [RES_W-1:0]  res_data,
    input  wire logic [1:0]        res_sel,
    input  wire logic              res_we,
    // Routing and output config
    input  wire logic [1:0]        main_src,
    input  wire logic [1:0]        io_src,
    input  wire logic              main_is_pwm,
    input  wire logic              io_pwm_en,
    input  wire logic [1:0]        pwm_res,
    input  wire logic [1:0]        pwm_div,
    input  wire logic              diag_high,
    // Alarm config, per channel
    input  wire logic [1:0]        alarm_en,
    input  wire logic [RES_W-1:0]  thr0,
    input  wire logic [RES_W-1:0]  thr1,
    input  wire logic [RES_W-1:0]  hyst0,
    input  wire logic [RES_W-1:0]  hyst1,
    input  wire logic [1:0]        alarm_inv,
    input  wire logic [1:0]        window_mode,
    input  wire logic [7:0]        on_dly0,
    input  wire logic [7:0]        on_dly1,
    input  wire logic [7:0]        off_dly0,
    input  wire logic [7:0]        off_dly1,
    // Serial interface control
    input  wire logic              spi_sel_cfg,
    input  wire logic              start_win_en,
    input  wire logic              ow_request,
    input  wire logic              ow_leave,
    input  wire logic              serial_data_out_line,
    input  wire logic              serial_data_out_line_act,
    input  wire logic [1:0]        supply_step_cfg,
    // Supervision inputs (async)
    input  wire logic              cmc_alive,
    input  wire logic              loop_alive,
    input  wire logic              wire_break,
    input  wire logic              cm_fault,
    input  wire logic              mem_mismatch,
    input  wire logic              sig_fail,
    input  wire logic              parity_fail,
    // Shared pins
    input  wire logic              second_shared_io_pin_in,
    output logic                   first_shared_io_pin_out,
    output logic                   first_shared_io_pin_oen,
    output logic                   second_shared_io_pin_out,
    output logic                   second_shared_io_pin_oen,
    output logic                   primary_pulse_output,
    // Status and analog code
    output logic [DAC_W-1:0]       dac_code,
    output logic                   main_analog_en,
    output logic [1:0]             serial_mode,
    output logic                   spi_cs_n,
    output logic [RES_W-1:0]       serial_result,
    output logic [1:0]             supply_step,
    output logic                   error_flag
);
    ////////////////////////////////////////////////////////////////////
    logic [RES_W-1:0] res_q [3];
    logic [RES_W-1:0] main_val;
    logic [RES_W-1:0] io_val;
    logic [6:0]       sync1_q;
    logic [6:0]       sync2_q;
    logic             cs_s1_q;
    logic             cs_s2_q;

    function automatic logic [RES_W-1:0] pick(input logic [1:0] s,
                                              input logic [RES_W-1:0] a,
                                              input logic [RES_W-1:0] b,
                                              input logic [RES_W-1:0] c);
        case (s)
            SEL_BRIDGE: pick = a;
            SEL_TEMP1:  pick = b;
            default:    pick = c;
        endcase
    endfunction

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            res_q[0] <= '0;
            res_q[1] <= '0;
            res_q[2] <= '0;
        end else if (res_we && res_sel != 2'h3) begin
            res_q[res_sel] <= res_data;
        end
    end

    assign main_val = pick(main_src, res_q[0], res_q[1], res_q[2]);
    assign io_val   = pick(io_src, res_q[0], res_q[1], res_q[2]);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
        end else begin
            sync1_q <= {cmc_alive, loop_alive, wire_break, cm_fault,
                        mem_mismatch, sig_fail, parity_fail};
            sync2_q <= sync1_q;
            cs_s1_q <= second_shared_io_pin_in;
            cs_s2_q <= cs_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Start window and serial mode
    logic [31:0] win_cnt_q;
    logic        win_open_q;
    logic        ow_stay_q;
    sosc_mode_e  mode_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt_q  <= '0;
            win_open_q <= 1'b1;
        end else if (win_open_q) begin
            if (!start_win_en || ow_request) begin
                win_open_q <= 1'b0;
            end else if (win_cnt_q == 32'(START_CYC - 1)) begin
                win_open_q <= 1'b0;
            end else begin
                win_cnt_q <= win_cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ow_stay_q <= 1'b0;
        end else if (win_open_q && start_win_en && ow_request) begin
            ow_stay_q <= 1'b1;
        end else if (ow_leave) begin
            ow_stay_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            mode_q <= SOSC_ONEWIRE;
        end else if ((win_open_q && start_win_en) || ow_stay_q
                     || (win_open_q && ow_request)) begin
            mode_q <= SOSC_ONEWIRE;
        end else begin
            mode_q <= spi_sel_cfg ? SOSC_SPI : SOSC_I2C;
        end
    end

    assign serial_mode = mode_q;
    assign spi_cs_n    = (mode_q == SOSC_SPI) ? cs_s2_q : 1'b1;
    assign supply_step = supply_step_cfg;

    ////////////////////////////////////////////////////////////////////
    // Supervision
    logic [31:0] wdg_cnt_q;
    logic        cmc_prev_q;
    logic        loop_prev_q;
    logic        cmc_seen_q;
    logic        loop_seen_q;
    logic        wdg_err_q;
    logic        err_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            wdg_cnt_q   <= '0;
            cmc_prev_q  <= 1'b0;
            loop_prev_q <= 1'b0;
            cmc_seen_q  <= 1'b0;
            loop_seen_q <= 1'b0;
            wdg_err_q   <= 1'b0;
        end else begin
            cmc_prev_q  <= sync2_q[6];
            loop_prev_q <= sync2_q[5];
            if (wdg_cnt_q == 32'(WDG_LIM - 1)) begin
                wdg_cnt_q <= '0;
                if (!cmc_seen_q || !loop_seen_q) begin
                    wdg_err_q <= 1'b1;
                end
                // Toggle on the last cycle counts for the next period
                cmc_seen_q  <= sync2_q[6] != cmc_prev_q;
                loop_seen_q <= sync2_q[5] != loop_prev_q;
            end else begin
                wdg_cnt_q <= wdg_cnt_q + 32'h1;
                if (sync2_q[6] != cmc_prev_q) begin
                    cmc_seen_q <= 1'b1;
                end
                if (sync2_q[5] != loop_prev_q) begin
                    loop_seen_q <= 1'b1;
                end
            end
        end
    end

    // Errors latch until power-on reset
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            err_q <= 1'b0;
        end else if (wdg_err_q || sync2_q[4] || sync2_q[3] || sync2_q[2]
                     || sync2_q[1] || sync2_q[0]) begin
            err_q <= 1'b1;
        end
    end
    assign error_flag = err_q;

    ////////////////////////////////////////////////////////////////////
    // DAC code and serial result
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dac_code      <= DAC_MIN;
            serial_result <= '0;
        end else if (err_q) begin
            dac_code      <= diag_high ? DAC_MAX : DAC_MIN;
            serial_result <= DIAG_CODE;
        end else begin
            dac_code      <= main_val[RES_W-1 -: DAC_W];
            serial_result <= main_val;
        end
    end
    assign main_analog_en = (mode_q != SOSC_ONEWIRE) && !main_is_pwm;

    ////////////////////////////////////////////////////////////////////
    // PWM: period 2^(9+res) ticks, tick every 2^div clocks
    logic [PWM_MAX_W-1:0] pwm_cnt_q;
    logic [2:0]           pre_q;
    logic [PWM_MAX_W-1:0] cnt_mask;
    logic [PWM_MAX_W-1:0] main_duty;
    logic [PWM_MAX_W-1:0] io_duty;
    logic                 tick;
    logic                 main_pwm_q;
    logic                 io_pwm_q;

    assign tick     = (pre_q & ((3'h1 << pwm_div) - 3'h1)) == 3'h0;
    assign cnt_mask = PWM_MAX_W'((13'h200 << pwm_res) - 13'h1);
    assign main_duty = main_val[RES_W-1 -: PWM_MAX_W] >> (2'h3 - pwm_res);
    assign io_duty   = io_val[RES_W-1 -: PWM_MAX_W] >> (2'h3 - pwm_res);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q      <= '0;
            pwm_cnt_q  <= '0;
            main_pwm_q <= 1'b0;
            io_pwm_q   <= 1'b0;
        end else begin
            pre_q <= pre_q + 3'h1;
            if (tick) begin
                pwm_cnt_q <= (pwm_cnt_q + 1'b1) & cnt_mask;
            end
            main_pwm_q <= err_q ? diag_high : (pwm_cnt_q < main_duty);
            io_pwm_q   <= pwm_cnt_q < io_duty;
        end
    end
    assign primary_pulse_output = main_is_pwm && mode_q != SOSC_ONEWIRE
                                  && main_pwm_q;

    ////////////////////////////////////////////////////////////////////
    // Alarm channels, bridge result only
    logic [1:0] alarm_q;
    logic [7:0] dly_q [2];
    logic [1:0] raw;
    logic [RES_W-1:0] br;

    assign br = res_q[0];

    always_comb begin
        raw = alarm_q;
        // Channel 0
        if (window_mode[0]) begin
            raw[0] = (br >= thr0 && br <= thr1) ^ alarm_inv[0];
        end else if (!alarm_q[0] ^ alarm_inv[0]) begin
            raw[0] = alarm_inv[0] ? (br < thr0) : (br > thr0);
        end else begin
            raw[0] = alarm_inv[0] ? !(br > thr0 + hyst0)
                                  : !(br < thr0 - hyst0);
        end
        // Channel 1
        if (window_mode[1]) begin
            raw[1] = (br >= thr0 && br <= thr1) ^ alarm_inv[1];
        end else if (!alarm_q[1] ^ alarm_inv[1]) begin
            raw[1] = alarm_inv[1] ? (br < thr1) : (br > thr1);
        end else begin
            raw[1] = alarm_inv[1] ? !(br > thr1 + hyst1)
                                  : !(br < thr1 - hyst1);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            alarm_q <= '0;
            dly_q[0] <= '0;
            dly_q[1] <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (raw[i] == alarm_q[i]) begin
                    dly_q[i] <= '0;
                end else if (dly_q[i] >= (raw[i]
                             ? (i == 0 ? on_dly0 : on_dly1)
                             : (i == 0 ? off_dly0 : off_dly1))) begin
                    alarm_q[i] <= raw[i];
                    dly_q[i]   <= '0;
                end else begin
                    dly_q[i] <= dly_q[i] + 8'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin arbitration; oen low means driving
    logic spi_m;
    assign spi_m = (mode_q == SOSC_SPI);

    always_comb begin
        first_shared_io_pin_oen = 1'b1;
        first_shared_io_pin_out = 1'b0;
        if (spi_m && serial_data_out_line_act) begin
            first_shared_io_pin_oen = 1'b0;
            first_shared_io_pin_out = serial_data_out_line;
        end else if (io_pwm_en) begin
            first_shared_io_pin_oen = 1'b0;
            first_shared_io_pin_out = io_pwm_q;
        end else if (alarm_en[0]) begin
            first_shared_io_pin_oen = 1'b0;
            first_shared_io_pin_out = alarm_q[0];
        end
    end

    always_comb begin
        second_shared_io_pin_oen = 1'b1;
        second_shared_io_pin_out = 1'b0;
        if (!spi_m && alarm_en[1]) begin
            second_shared_io_pin_oen = 1'b0;
            second_shared_io_pin_out = alarm_q[1];
        end
    end
endmodule

// File: hdl/sosc_pkg.sv
// Purpose: Shared constants for the sensor output stage control block
// Assumes: 250 MHz ref_clk
// Notes:   Times are given in their own unit, cycle counts derived
package sosc_pkg;
    localparam int          CLK_MHZ        = 250;
    localparam int          RES_W          = 15;
    localparam int          DAC_W          = 11;
    localparam int          PWM_MAX_W      = 12;
    localparam int          START_WIN_MS   = 20;
    localparam int          START_WIN_CYC  = START_WIN_MS * 1000 * CLK_MHZ;
    localparam int          WDG_US         = 100;
    localparam int          WDG_CYC        = WDG_US * CLK_MHZ;
    localparam logic [14:0] DIAG_CODE      = 15'h7ff0;
    localparam logic [10:0] DAC_MAX        = 11'h7ff;
    localparam logic [10:0] DAC_MIN        = 11'h000;
    // Result selectors
    localparam logic [1:0]  SEL_BRIDGE     = 2'h0;
    localparam logic [1:0]  SEL_TEMP1      = 2'h1;
    localparam logic [1:0]  SEL_TEMP2      = 2'h2;
    // Serial modes
    typedef enum logic [1:0] {
        SOSC_ONEWIRE = 2'b00,
        SOSC_I2C     = 2'b01,
        SOSC_SPI     = 2'b10
    } sosc_mode_e;
endpackage

// File: test/sosc_top_asserts.sv
// Purpose: Port-level checks for the output stage control block
// Assumes: Config ports stay stable outside reset
// Notes:   Bound to every sosc_top instance
`timescale 1ns/10ps
module sosc_top_chk
    import sosc_pkg::*;
#(
    parameter int START_CYC = START_WIN_CYC
) (
    // Clock and reset
    input wire logic              ref_clk,
    input wire logic              resetn,
    // Stimulus side
    input wire logic [RES_W-1:0]  res_data,
    input wire logic [1:0]        res_sel,
    input wire logic              res_we,
    input wire logic [1:0]        main_src,
    input wire logic              main_is_pwm,
    input wire logic              io_pwm_en,
    input wire logic              diag_high,
    input wire logic              start_win_en,
    input wire logic              serial_data_out_line,
    input wire logic              serial_data_out_line_act,
    input wire logic              wire_break,
    input wire logic              cm_fault,
    input wire logic              mem_mismatch,
    // Design outputs
    input wire logic              first_shared_io_pin_out,
    input wire logic              first_shared_io_pin_oen,
    input wire logic              second_shared_io_pin_oen,
    input wire logic [DAC_W-1:0]  dac_code,
    input wire logic [1:0]        serial_mode,
    input wire logic              spi_cs_n,
    input wire logic [RES_W-1:0]  serial_result,
    input wire logic              error_flag
);
    logic [RES_W-1:0] d1_q;
    logic [RES_W-1:0] d2_q;
    int               cnt_q;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////
    // Data pipe and cycle count since reset release
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            d1_q  <= '0;
            d2_q  <= '0;
            cnt_q <= 0;
        end else begin
            d1_q  <= res_data;
            d2_q  <= d1_q;
            cnt_q <= (cnt_q < START_CYC + 8) ? cnt_q + 1 : cnt_q;
        end
    end
    ////////////////////////////////////////////////////////////////////
    property p_win;
        start_win_en && cnt_q < START_CYC |-> serial_mode == SOSC_ONEWIRE;
    endproperty
    a_win: assert property (p_win) else $error("left one-wire early");
    property p_dac;
        res_we && res_sel == SEL_BRIDGE && main_src == SEL_BRIDGE
            && !main_is_pwm |-> ##2 (error_flag || dac_code == d2_q[14:4]);
    endproperty
    a_dac: assert property (p_dac) else $error("dac code wrong");
    property p_alm2;
        serial_mode == SOSC_SPI |-> second_shared_io_pin_oen;
    endproperty
    a_alm2: assert property (p_alm2) else $error("pin two driven");
    property p_cs;
        serial_mode != SOSC_SPI |-> spi_cs_n;
    endproperty
    a_cs: assert property (p_cs) else $error("select low off spi");
    property p_sdo;
        serial_mode == SOSC_SPI && io_pwm_en && serial_data_out_line_act
            |-> !first_shared_io_pin_oen && first_shared_io_pin_out == serial_data_out_line;
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo not on pin one");
    property p_sticky;
        error_flag |=> error_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("error dropped");
    property p_code;
        error_flag |=> serial_result == DIAG_CODE;
    endproperty
    a_code: assert property (p_code) else $error("no error code");
    property p_dmax;
        error_flag && !main_is_pwm
            |=> dac_code == (diag_high ? DAC_MAX : DAC_MIN);
    endproperty
    a_dmax: assert property (p_dmax) else $error("dac not forced");
    property p_wb;
        $rose(wire_break) |-> ##[1:4] error_flag;
    endproperty
    a_wb: assert property (p_wb) else $error("break not flagged");
    property p_cm;
        $rose(cm_fault) |-> ##[1:4] error_flag;
    endproperty
    a_cm: assert property (p_cm) else $error("cm not flagged");
    property p_mem;
        $rose(mem_mismatch) |-> ##[1:4] error_flag;
    endproperty
    a_mem: assert property (p_mem) else $error("mismatch not flagged");
endmodule
bind sosc_top sosc_top_chk #(.START_CYC(START_CYC)) sosc_top_chk_i (.*);

// File: test/sosc_host_model.sv
// Purpose: Serial host facing the block
// Assumes: Select line idles high, driven high by this model
// Notes:   Each bit lasts eight clocks, 32 ns
`timescale 1ns/10ps
module sosc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Serial lines
    output logic      ow_request,
    output logic      ow_leave,
    output logic      serial_data_out_line,
    output logic      serial_data_out_line_act,
    output logic      sel_n
);
    initial begin
        {ow_request, ow_leave, serial_data_out_line, serial_data_out_line_act} = 4'h0;
        sel_n = 1'h1;
    end
    // One-cycle request or leave command
    task automatic ow_pulse(input logic leave);
        @(posedge ref_clk);
        ow_request <= !leave;
        ow_leave <= leave;
        @(posedge ref_clk);
        ow_request <= 1'h0;
        ow_leave <= 1'h0;
    endtask
    // Byte frame, 32 ns link clock
    task automatic spi_frame(input logic [7:0] b);
        @(posedge ref_clk);
        sel_n <= 1'h0;
        serial_data_out_line_act <= 1'h1;
        for (int i = 7; i >= 0; i--) begin
            serial_data_out_line <= b[i];
            repeat (8) @(posedge ref_clk);
        end
        sel_n <= 1'h1;
        serial_data_out_line_act <= 1'h0;
        serial_data_out_line <= ~b[0];
    endtask
endmodule

// File: test/tb.sv
// Purpose: Self-checking bench for sosc_top
// Assumes: Shortened window and watchdog counts
// Notes:   Bench inputs change on the falling edge, host model lines on the rising edge
`timescale 1ns/10ps
module tb;
    import sosc_pkg::*;
    logic ref_clk = 1'h0, resetn = 1'h0, res_we = 1'h0, hb_en = 1'h1;
    logic [14:0] res_data = '0, thr0 = 15'h4000, thr1 = 15'h6000;
    logic [14:0] hyst0 = 15'h0100, hyst1 = 15'h0100;
    logic [1:0] res_sel = '0, main_src = '0, io_src = 2'h1, pwm_res = '0;
    logic [1:0] pwm_div = '0, alarm_en = '0, alarm_inv = '0;
    logic [1:0] window_mode = '0, supply_step_cfg = 2'h2;
    logic [7:0] on_dly0 = '0, on_dly1 = '0, off_dly0 = '0, off_dly1 = '0;
    logic main_is_pwm = 1'h0, io_pwm_en = 1'h0, diag_high = 1'h1;
    logic spi_sel_cfg = 1'h0, start_win_en = 1'h1;
    logic cmc_alive = 1'h0, loop_alive = 1'h0;
    logic [3:0] hb_q = '0;
    logic [4:0] errs = '0;
    logic [14:0] hi_cnt = '0;
    wire wire_break = errs[0], cm_fault = errs[1], mem_mismatch = errs[2];
    wire sig_fail = errs[3], parity_fail = errs[4];
    wire ow_request, ow_leave, serial_data_out_line, serial_data_out_line_act, second_shared_io_pin_in;
    wire first_shared_io_pin_out, first_shared_io_pin_oen, main_analog_en;
    wire second_shared_io_pin_out, second_shared_io_pin_oen, spi_cs_n;
    wire primary_pulse_output, error_flag;
    wire [10:0] dac_code;
    wire [1:0] serial_mode, supply_step;
    wire [14:0] serial_result;
    int bad_count = 0, n_checks = 0, tmo = 0;
    sosc_top #(.START_CYC(200), .WDG_LIM(64)) sosc_top_i (.*);
    sosc_host_model sosc_host_model_i (.ref_clk(ref_clk),
        .ow_request(ow_request), .ow_leave(ow_leave), .serial_data_out_line(serial_data_out_line),
        .serial_data_out_line_act(serial_data_out_line_act), .sel_n(second_shared_io_pin_in));
    always #2 ref_clk = ~ref_clk;
    // Heartbeats toggle every 16 cycles while enabled
    always @(negedge ref_clk) begin
        if (hb_en) begin
            hb_q <= hb_q + 4'h1;
            cmc_alive <= cmc_alive ^ (hb_q == 4'hf);
            loop_alive <= loop_alive ^ (hb_q == 4'hf);
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [14:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic rst(input logic w, input logic s);
        resetn = 1'h0;
        start_win_en = w;
        spi_sel_cfg = s;
        errs = '0;
        hb_en = 1'h1;
        cyc(20);
        resetn = 1'h1;
    endtask
    task automatic wr(input logic [1:0] sel, input logic [14:0] d);
        res_sel = sel;
        res_data = d;
        res_we = 1'h1;
        cyc(1);
        res_we = 1'h0;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        tmo++;
        if (tmo == 5000) begin
            bad_count++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        cyc(1);
        rst(1'h1, 1'h1);
        chk("mode_rst", serial_mode, SOSC_ONEWIRE);
        chk("dac_rst", dac_code, 11'h0);
        cyc(195);
        chk("mode_win", serial_mode, SOSC_ONEWIRE);
        cyc(10);
        chk("mode_spi", serial_mode, SOSC_SPI);
        chk("io2_oen", second_shared_io_pin_oen, 1'h1);
        chk("analog_en", main_analog_en, 1'h1);
        io_pwm_en = 1'h1;
        fork
            sosc_host_model_i.spi_frame(8'ha5);
            begin
                cyc(12);
                chk("cs_frame", spi_cs_n, 1'h0);
                chk("io1_sdo", first_shared_io_pin_out, 1'h0);
                chk("io1_oen", first_shared_io_pin_oen, 1'h0);
            end
        join
        cyc(1);
        wr(SEL_BRIDGE, 15'h5a5a);
        wr(SEL_TEMP1, 15'h1234);
        cyc(1);
        chk("dac_bridge", dac_code, 11'h5a5);
        main_src = SEL_TEMP1;
        cyc(3);
        chk("dac_temp1", dac_code, 11'h123);
        chk("no_err", error_flag, 1'h0);
        main_src = SEL_BRIDGE;
        rst(1'h1, 1'h0);
        cyc(50);
        sosc_host_model_i.ow_pulse(1'h0);
        cyc(250);
        chk("ow_stay", serial_mode, SOSC_ONEWIRE);
        sosc_host_model_i.ow_pulse(1'h1);
        cyc(4);
        chk("ow_left", serial_mode, SOSC_I2C);
        io_pwm_en = 1'h0;
        rst(1'h0, 1'h0);
        cyc(3);
        chk("no_win", serial_mode, SOSC_I2C);
        chk("supply", supply_step, 2'h2);
        alarm_en = 2'h1;
        wr(SEL_TEMP1, 15'h7000);
        cyc(20);
        chk("alm_temp", first_shared_io_pin_out, 1'h0);
        wr(SEL_BRIDGE, 15'h5000);
        cyc(4);
        chk("alm_on", first_shared_io_pin_out, 1'h1);
        wr(SEL_BRIDGE, 15'h1000);
        cyc(4);
        chk("alm_off", first_shared_io_pin_out, 1'h0);
        main_is_pwm = 1'h1;
        wr(SEL_BRIDGE, 15'h4000);
        cyc(4);
        for (int i = 0; i < 512; i++) begin
            cyc(1);
            hi_cnt = hi_cnt + 15'(primary_pulse_output);
        end
        chk("pwm_duty", hi_cnt, 15'h0100);
        main_is_pwm = 1'h0;
        alarm_en = 2'h3;
        window_mode = 2'h2;
        off_dly1 = 8'h05;
        cyc(4);
        chk("alm_win_in", second_shared_io_pin_out, 1'h1);
        wr(SEL_BRIDGE, 15'h7000);
        cyc(4);
        chk("alm_dly", second_shared_io_pin_out, 1'h1);
        cyc(4);
        chk("alm_win_out", second_shared_io_pin_out, 1'h0);
        for (int k = 0; k < 5; k++) begin
            diag_high = k[0];
            rst(1'h1, 1'h0);
            cyc(5);
            errs[k] = 1'h1;
            cyc(5);
            chk("err_flag", error_flag, 1'h1);
            chk("err_code", serial_result, DIAG_CODE);
            chk("err_dac", dac_code, k[0] ? DAC_MAX : DAC_MIN);
        end
        rst(1'h1, 1'h0);
        cyc(10);
        hb_en = 1'h0;
        for (int i = 0; i < 300 && error_flag !== 1'h1; i++) cyc(1);
        chk("wdog", error_flag, 1'h1);
        print_verdict();
    end
endmodule
